// *** design/mps_sequencer.sv ***
// Purpose: power-state sequencer of a plug-in cellular data card
// Assumes: reset_n follows main supply presence; host drives pins
// Notes: control and status reached over Avalon-MM with waitrequest
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module mps_sequencer
   import mps_pkg::*;
#(
   parameter logic [MPS_CNT_W-1:0] BOOT_CYCLES = MPS_BOOT_CYCLES[MPS_CNT_W-1:0],
   parameter logic [MPS_CNT_W-1:0] RESTART_CYCLES = MPS_RESTART_CYCLES[MPS_CNT_W-1:0],
   parameter logic [MPS_CNT_W-1:0] FINAL_CYCLES = MPS_FINAL_CYCLES[MPS_CNT_W-1:0]
) (
   // clock and main supply reset
   input wire logic clk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // host control pins
   input wire logic card_power_en,
   input wire logic hard_restart_in_n,
   input wire logic [MPS_GPIO_W-1:0] gpio_in,
   input wire logic host_if_sel,
   // status pins
   output logic ref_rail_out,
   output logic boot_ok_out,
   output logic host_if_pcie_out
);

   // synchronised pins, power pin used unsynchronised
   logic [MPS_GPIO_W+1:0] pins_sync;
   logic power_s;
   logic restart_n_s;
   logic [MPS_GPIO_W-1:0] gpio_s;

   // sequencer state
   mps_state_t state_reg;
   mps_state_t state_next;
   logic [MPS_CNT_W-1:0] seq_cnt_reg;
   logic booted_reg;
   logic fast_cause_reg;

   // hard restart measurement
   logic [MPS_CNT_W-1:0] low_cnt_reg;
   logic restart_prev_reg;
   logic restart_fire_reg;

   // fast trigger edge detection
   logic [MPS_GPIO_W-1:0] gpio_prev_reg;
   logic trig_now;
   logic fast_edge;

   // configuration
   logic ind_en_reg;
   logic fast_en_reg;
   logic [1:0] fast_sel_reg;

   // bus helpers and the boot-entry strobe
   logic bus_req;
   logic bus_ack;
   logic [31:0] status_word;
   logic [31:0] ctrl_word;
   logic enter_boot;

   // all six pins idle high so no restart or edge is seen at release
   mps_sync #(
      .W(MPS_GPIO_W + 2),
      .RST_VAL({(MPS_GPIO_W + 2){1'b1}})
   ) u_pin_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({host_if_sel, hard_restart_in_n, gpio_in}),
      .q(pins_sync)
   );

   assign restart_n_s = pins_sync[MPS_GPIO_W];
   assign gpio_s = pins_sync[MPS_GPIO_W-1:0];
   // power control is kept off the synchroniser reset value of one
   assign power_s = card_power_en;

   // selected trigger line and its falling edge
   assign trig_now = gpio_s[fast_sel_reg];
   assign fast_edge = fast_en_reg && gpio_prev_reg[fast_sel_reg] && !trig_now;

   // last level of every line, so a new selection cannot fake an edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gpio_prev_reg <= '1;
      end else begin
         gpio_prev_reg <= gpio_s;
      end
   end

   // reset low time, saturating so a long hold never wraps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_reg <= MPS_CNT_ZERO;
      end else if (restart_n_s) begin
         low_cnt_reg <= MPS_CNT_ZERO;
      end else if (low_cnt_reg <= RESTART_CYCLES) begin
         low_cnt_reg <= low_cnt_reg + MPS_CNT_ONE;
      end
   end

   // restart fires on release, only after more than the hold time
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         restart_prev_reg <= 1'b1;
         restart_fire_reg <= 1'b0;
      end else begin
         restart_prev_reg <= restart_n_s;
         restart_fire_reg <= restart_n_s && !restart_prev_reg
                             && (low_cnt_reg > RESTART_CYCLES);
      end
   end

   // next state
   always_comb begin
      state_next = state_reg;
      if (restart_fire_reg) begin
         state_next = MPS_BOOT;
      end else begin
         unique case (state_reg)
            MPS_OFF: begin
               // low level on restart pin also powers up
               if (power_s || !restart_n_s) begin
                  state_next = MPS_BOOT;
               end
            end
            MPS_BOOT: begin
               // graceful request has no effect here
               if (fast_edge) begin
                  state_next = MPS_FINAL;
               end else if (seq_cnt_reg >= BOOT_CYCLES - MPS_CNT_ONE) begin
                  state_next = MPS_ACTIVE;
               end
            end
            MPS_ACTIVE: begin
               if (!power_s || fast_edge) begin
                  state_next = MPS_FINAL;
               end
            end
            MPS_FINAL: begin
               // power and trigger pins ignored until the finalization count expires
               if (seq_cnt_reg >= FINAL_CYCLES - MPS_CNT_ONE) begin
                  state_next = MPS_DOWN;
               end
            end
            MPS_DOWN: begin
               // after a fast shutdown with the indicator in use the card stays off
               if (fast_cause_reg && ind_en_reg) begin
                  state_next = MPS_HALT;
               end else begin
                  state_next = MPS_OFF;
               end
            end
            MPS_HALT: begin
               state_next = MPS_HALT;
            end
         endcase
      end
   end

   assign enter_boot = (state_next == MPS_BOOT) && (state_reg != MPS_BOOT || restart_fire_reg);

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= MPS_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // phase counter, restarted on every state change
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seq_cnt_reg <= MPS_CNT_ZERO;
      end else if (state_next != state_reg || enter_boot) begin
         seq_cnt_reg <= MPS_CNT_ZERO;
      end else if (state_reg == MPS_BOOT || state_reg == MPS_FINAL) begin
         seq_cnt_reg <= seq_cnt_reg + MPS_CNT_ONE;
      end
   end

   // boot-done flag and shutdown cause
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         booted_reg <= 1'b0;
         fast_cause_reg <= 1'b0;
      end else if (enter_boot) begin
         booted_reg <= 1'b0;
         fast_cause_reg <= 1'b0;
      end else begin
         if (state_next == MPS_ACTIVE) begin
            booted_reg <= 1'b1;
         end else if (state_next == MPS_DOWN || state_next == MPS_OFF) begin
            booted_reg <= 1'b0;
         end
         if (state_reg != MPS_FINAL && state_next == MPS_FINAL) begin
            fast_cause_reg <= fast_edge;
         end
      end
   end

   // host interface choice latched as power-on begins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         host_if_pcie_out <= 1'b0;
      end else if (enter_boot) begin
         host_if_pcie_out <= !pins_sync[MPS_GPIO_W+1];
      end
   end

   // pin outputs straight from flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ref_rail_out <= 1'b0;
         boot_ok_out <= 1'b0;
      end else begin
         // rail falls only when finalization is over
         ref_rail_out <= (state_next == MPS_BOOT) || (state_next == MPS_ACTIVE)
                         || (state_next == MPS_FINAL);
         // indicator stays low unless software turned it on
         boot_ok_out <= ind_en_reg && !enter_boot
                        && ((state_next == MPS_ACTIVE) || (state_next == MPS_FINAL));
      end
   end

   // avalon handshake: one wait cycle, then a single answer cycle
   assign bus_req = (avs_read || avs_write) && !(avs_read && avs_write);
   assign bus_ack = bus_req && !avs_waitrequest;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !(bus_req && avs_waitrequest);
      end
   end

   // register views
   always_comb begin
      ctrl_word = MPS_DATA_ZERO;
      ctrl_word[MPS_CTRL_IND_EN_BIT] = ind_en_reg;
      ctrl_word[MPS_CTRL_FAST_EN_BIT] = fast_en_reg;
      ctrl_word[MPS_CTRL_SEL_MSB:MPS_CTRL_SEL_LSB] = fast_sel_reg;
      status_word = MPS_DATA_ZERO;
      status_word[MPS_ST_RAIL_BIT] = ref_rail_out;
      status_word[MPS_ST_BOOTED_BIT] = booted_reg;
      status_word[MPS_ST_PCIE_BIT] = host_if_pcie_out;
      status_word[MPS_ST_FINAL_BIT] = (state_reg == MPS_FINAL);
      status_word[MPS_ST_HALT_BIT] = (state_reg == MPS_HALT);
      status_word[MPS_ST_FAST_BIT] = fast_cause_reg;
   end

   // read data loaded as waitrequest drops, unmapped reads zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= MPS_DATA_ZERO;
      end else if (avs_read && !avs_write && avs_waitrequest) begin
         unique case (avs_address)
            MPS_CTRL_OFS: avs_readdata <= ctrl_word;
            MPS_STATUS_OFS: avs_readdata <= status_word;
            default: avs_readdata <= MPS_DATA_ZERO;
         endcase
      end
   end

   // configuration, wiped at every power-up so features start disabled
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ind_en_reg <= 1'b0;
         fast_en_reg <= 1'b0;
         fast_sel_reg <= 2'h0;
      end else if (enter_boot) begin
         ind_en_reg <= 1'b0;
         fast_en_reg <= 1'b0;
         fast_sel_reg <= 2'h0;
      end else if (bus_ack && avs_write && avs_address == MPS_CTRL_OFS
                   && avs_byteenable[0]) begin
         ind_en_reg <= avs_writedata[MPS_CTRL_IND_EN_BIT];
         fast_en_reg <= avs_writedata[MPS_CTRL_FAST_EN_BIT];
         fast_sel_reg <= avs_writedata[MPS_CTRL_SEL_MSB:MPS_CTRL_SEL_LSB];
      end
   end

endmodule

// *** design/mps_pkg.sv ***
// Purpose: shared constants for the module power sequencer
// Assumes: 50 MHz core clock, main supply presence acts as reset_n
// Notes: times kept in their own units, cycle counts derived from them
package mps_pkg;

   // clock
   localparam longint unsigned MPS_CLK_HZ = 64'd50_000_000;

   // timing, figures in their own units
   localparam longint unsigned MPS_BOOT_TIME_S = 64'd50;
   localparam longint unsigned MPS_RESTART_TIME_S = 64'd1;
   localparam longint unsigned MPS_FINAL_TIME_MS = 64'd100;

   // derived cycle counts (least times, exact divisions here)
   localparam longint unsigned MPS_BOOT_CYCLES = MPS_BOOT_TIME_S * MPS_CLK_HZ;
   localparam longint unsigned MPS_RESTART_CYCLES = MPS_RESTART_TIME_S * MPS_CLK_HZ;
   localparam longint unsigned MPS_FINAL_CYCLES = (MPS_FINAL_TIME_MS * MPS_CLK_HZ) / 64'd1000;

   // register byte offsets
   localparam logic [3:0] MPS_CTRL_OFS = 4'h0;
   localparam logic [3:0] MPS_STATUS_OFS = 4'h4;

   // control register fields
   localparam int MPS_CTRL_IND_EN_BIT = 0;
   localparam int MPS_CTRL_FAST_EN_BIT = 1;
   localparam int MPS_CTRL_SEL_LSB = 2;
   localparam int MPS_CTRL_SEL_MSB = 3;

   // status register fields
   localparam int MPS_ST_RAIL_BIT = 0;
   localparam int MPS_ST_BOOTED_BIT = 1;
   localparam int MPS_ST_PCIE_BIT = 2;
   localparam int MPS_ST_FINAL_BIT = 3;
   localparam int MPS_ST_HALT_BIT = 4;
   localparam int MPS_ST_FAST_BIT = 5;

   // widths and reset values
   localparam int MPS_GPIO_W = 4;
   localparam int MPS_CNT_W = 32;
   localparam logic [31:0] MPS_DATA_ZERO = 32'h0000_0000;
   localparam logic [MPS_CNT_W-1:0] MPS_CNT_ZERO = 32'h0000_0000;
   localparam logic [MPS_CNT_W-1:0] MPS_CNT_ONE = 32'h0000_0001;

   // sequencer states
   typedef enum logic [2:0] {
      MPS_OFF,
      MPS_BOOT,
      MPS_ACTIVE,
      MPS_FINAL,
      MPS_DOWN,
      MPS_HALT
   } mps_state_t;

endpackage

// *** design/mps_sync.sv ***
// Purpose: two-flop synchroniser for a group of level inputs
// Assumes: inputs are levels that stay put for several clocks
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module mps_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_reg;

   // double flop, idle value loaded under reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule

// *** verif/mps_seq_monitor.sv ***
// Purpose: port checker for the power sequencer
// Assumes: bench runs short counts, finalize span of 8
// Notes: bound from the bench top file
`timescale 1ns/10ps
module mps_seq_monitor
   import mps_pkg::*;
#(
   parameter logic [MPS_CNT_W-1:0] BOOT_CYCLES = 32'h0000_0014,
   parameter logic [MPS_CNT_W-1:0] RESTART_CYCLES = 32'h0000_000a
) (
   // clock and supply reset
   input wire logic clk,
   input wire logic reset_n,
   // bus handshake
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // power pins
   input wire logic card_power_en,
   input wire logic hard_restart_in_n,
   input wire logic ref_rail_out,
   input wire logic boot_ok_out,
   input wire logic host_if_pcie_out
);
   logic [MPS_CNT_W-1:0] on_cnt;
   logic [MPS_CNT_W-1:0] low_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // cycles with rail up, saturating so it never wraps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) on_cnt <= MPS_CNT_ZERO;
      else if (!ref_rail_out) on_cnt <= MPS_CNT_ZERO;
      else if (on_cnt != '1) on_cnt <= on_cnt + MPS_CNT_ONE;
   end
   // length of the current restart low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) low_cnt <= MPS_CNT_ZERO;
      else if (hard_restart_in_n) low_cnt <= MPS_CNT_ZERO;
      else if (low_cnt != '1) low_cnt <= low_cnt + MPS_CNT_ONE;
   end
   // bus answer timing
   AST_WAIT_ONE: assert property ((avs_read ^ avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low for more than one cycle");
   // indicator and rail relations
   AST_IND_DEFAULT: assert property ($rose(ref_rail_out) |-> !boot_ok_out)
      else $error("indicator high at power up");
   AST_BOOT_TIME: assert property ($rose(boot_ok_out) |-> on_cnt >= BOOT_CYCLES)
      else $error("indicator before boot time");
   AST_RAIL_DROP: assert property ($fell(ref_rail_out) |-> !boot_ok_out)
      else $error("indicator outlives rail");
   AST_GRACE: assert property ($fell(card_power_en) && boot_ok_out && hard_restart_in_n
      |-> ref_rail_out [*8] ##[1:30] !ref_rail_out)
      else $error("graceful shutdown timing wrong");
   AST_BOOT_HOLD: assert property ($fell(card_power_en) && ref_rail_out
      && on_cnt + 3 < BOOT_CYCLES |=> ref_rail_out [*8])
      else $error("early power drop cut boot short");
   AST_PCIE_HOLD: assert property (ref_rail_out && $past(ref_rail_out)
      |-> $stable(host_if_pcie_out))
      else $error("interface choice moved while on");
   AST_RESTART: assert property ($rose(hard_restart_in_n) && low_cnt > RESTART_CYCLES + 4
      |-> ##[2:12] (ref_rail_out && !boot_ok_out))
      else $error("long restart did not reboot");
   // main scenarios
   CV_DOWN: cover property ($fell(ref_rail_out));
   CV_IND: cover property ($rose(boot_ok_out));
   CV_RST: cover property ($rose(hard_restart_in_n) && low_cnt > RESTART_CYCLES + 4);
endmodule

// *** verif/mps_host_model.sv ***
// Purpose: host board driving the power pins
// Assumes: bench sets the wished levels
// Notes: restart hold length is the bench's choice
`timescale 1ns/10ps
module mps_host_model
   import mps_pkg::*;
(
   // clock and supply
   input wire logic clk,
   input wire logic reset_n,
   // wishes from the bench
   input wire logic power_req,
   input wire logic restart_req,
   input wire logic [MPS_GPIO_W-1:0] line_lvl,
   // device pins
   input wire logic ref_rail_out,
   output logic card_power_en,
   output logic hard_restart_in_n,
   output logic [MPS_GPIO_W-1:0] gpio_in
);
   // pins change only after a clock edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         card_power_en <= 1'b0;
         hard_restart_in_n <= 1'b1;
         gpio_in <= 4'h0;
      end else begin
         card_power_en <= power_req;
         hard_restart_in_n <= !restart_req;
         gpio_in <= ref_rail_out ? line_lvl : 4'h0;
      end
   end
endmodule

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the power sequencer
// Assumes: short boot, restart and finalize counts
// Notes: power pins come from the host model
`timescale 1ns/10ps
module testbench
   import mps_pkg::*;
();
   localparam logic [MPS_CNT_W-1:0] BOOT = 32'h0000_0014;
   localparam logic [MPS_CNT_W-1:0] RSTC = 32'h0000_000a;
   logic clk, reset_n, avs_read, avs_write, avs_waitrequest, host_if_sel, pw, rst;
   logic card_power_en, hard_restart_in_n, ref_rail_out, boot_ok_out, host_if_pcie_out;
   logic [3:0] avs_address, avs_byteenable, lines, gpio_in;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [1:0] sel;
   int mismatches, checks_done, p;
   mps_sequencer #(.BOOT_CYCLES(BOOT), .RESTART_CYCLES(RSTC),
      .FINAL_CYCLES(32'h0000_0008)) mps_sequencer_inst (.clk(clk), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .card_power_en(card_power_en), .hard_restart_in_n(hard_restart_in_n),
      .gpio_in(gpio_in), .host_if_sel(host_if_sel), .ref_rail_out(ref_rail_out),
      .boot_ok_out(boot_ok_out), .host_if_pcie_out(host_if_pcie_out));
   mps_host_model mps_host_model_inst (.clk(clk), .reset_n(reset_n), .power_req(pw),
      .restart_req(rst), .line_lvl(lines), .ref_rail_out(ref_rail_out),
      .card_power_en(card_power_en), .hard_restart_in_n(hard_restart_in_n),
      .gpio_in(gpio_in));
   // clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one bus access, held until wait is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
      chk(q, exp);
   endtask
   // expected status from rail, booted and interface
   function automatic logic [31:0] st(input int r, input int b, input int i);
      return 32'((r << MPS_ST_RAIL_BIT) | (b << MPS_ST_BOOTED_BIT) | (i << MPS_ST_PCIE_BIT));
   endfunction
   // bounded wait for a rail level
   task automatic rail(input logic v);
      repeat (60) if (ref_rail_out !== v) @(posedge clk);
      chk(32'(ref_rail_out), 32'(v));
   endtask
   // fall on one line for a few cycles
   task automatic pulse(input logic [1:0] n);
      lines <= ~(4'h1 << n);
      repeat (4) @(posedge clk);
      lines <= 4'hf;
      repeat (4) @(posedge clk);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
   // main sequence
   initial begin
      void'($urandom(32'h3e50c666));
      {reset_n, avs_read, avs_write, pw, rst, host_if_sel} = 6'h00;
      {avs_address, avs_byteenable, lines, avs_writedata} = 44'h0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rd(MPS_STATUS_OFS, st(0, 0, 0));
      rd(MPS_CTRL_OFS, 32'h0000_0000);
      rd(4'h8, 32'h0000_0000);
      pw <= 1'b1;
      rail(1'b1);
      rd(MPS_STATUS_OFS, st(1, 0, 1));
      repeat (BOOT + 4) @(posedge clk);
      rd(MPS_STATUS_OFS, st(1, 1, 1));
      chk(32'(boot_ok_out), 32'h0000_0000);
      bus(1'b1, MPS_CTRL_OFS, 32'h0000_0001, 4'h0);
      bus(1'b1, MPS_STATUS_OFS, 32'hffff_ffff, 4'hf);
      rd(MPS_STATUS_OFS, st(1, 1, 1));
      bus(1'b1, MPS_CTRL_OFS, 32'h0000_0001, 4'h1);
      repeat (2) @(posedge clk);
      chk(32'(boot_ok_out), 32'h0000_0001);
      pw <= 1'b0;
      repeat (3) @(posedge clk);
      pw <= 1'b1;
      rail(1'b0);
      rail(1'b1);
      pw <= 1'b0;
      repeat (10) @(posedge clk);
      chk(32'(ref_rail_out), 32'h0000_0001);
      rail(1'b0);
      sel = 2'($urandom_range(3));
      host_if_sel <= 1'($urandom_range(1));
      lines <= 4'hf;
      repeat (4) @(posedge clk);
      p = !host_if_sel;
      pw <= 1'b1;
      rail(1'b1);
      chk(32'(host_if_pcie_out), 32'(p));
      repeat (BOOT + 4) @(posedge clk);
      pulse(sel);
      rd(MPS_STATUS_OFS, st(1, 1, p));
      bus(1'b1, MPS_CTRL_OFS, {28'h0, sel, 2'b10}, 4'h1);
      rd(MPS_CTRL_OFS, {28'h0, sel, 2'b10});
      pulse(sel ^ 2'b01);
      rd(MPS_STATUS_OFS, st(1, 1, p));
      pulse(sel);
      rail(1'b0);
      rail(1'b1);
      repeat (BOOT + 4) @(posedge clk);
      bus(1'b1, MPS_CTRL_OFS, {28'h0, sel, 2'b11}, 4'h1);
      pulse(sel);
      rail(1'b0);
      repeat (30) @(posedge clk);
      chk(32'(ref_rail_out), 32'h0000_0000);
      bus(1'b0, MPS_STATUS_OFS, 32'h0000_0000, 4'hf);
      chk((q >> MPS_ST_HALT_BIT) & 32'h0000_0003, 32'h0000_0003);
      rst <= 1'b1;
      repeat (RSTC + 6) @(posedge clk);
      rst <= 1'b0;
      rail(1'b1);
      repeat (BOOT + 4) @(posedge clk);
      bus(1'b1, MPS_CTRL_OFS, 32'h0000_0001, 4'h1);
      rst <= 1'b1;
      repeat (RSTC - 3) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      chk(32'(boot_ok_out), 32'h0000_0001);
      // supply removed mid-run, then power-up from off by the restart pin
      pw <= 1'b0;
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rd(MPS_STATUS_OFS, st(0, 0, 0));
      rd(MPS_CTRL_OFS, 32'h0000_0000);
      rst <= 1'b1;
      rail(1'b1);
      rst <= 1'b0;
      chk(32'(boot_ok_out), 32'h0000_0000);
      conclude();
   end
endmodule
bind mps_sequencer mps_seq_monitor #(.BOOT_CYCLES(BOOT_CYCLES),
   .RESTART_CYCLES(RESTART_CYCLES)) mon_inst (.clk(clk), .reset_n(reset_n),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .card_power_en(card_power_en), .hard_restart_in_n(hard_restart_in_n),
   .ref_rail_out(ref_rail_out), .boot_ok_out(boot_ok_out),
   .host_if_pcie_out(host_if_pcie_out));
